/* File: pbs_bar_sriov_config.sv */
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module pbs_bar_sriov_config (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    // Request decode
    input wire logic req_valid,
    input wire logic req_io,
    input wire logic [63:0] req_addr,
    output var pbs_pkg::pbs_hit_s hit,
    // SR-IOV capability settings
    output var pbs_pkg::pbs_sriov_s [pbs_pkg::NUM_PF-1:0] sriov_cfg
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [1:0] rst_pipe;
    logic rst_sync_b;
    logic ctrl_legacy;
    logic ctrl_root;
    pbs_pkg::pbs_bar_cfg_s bar_cfg [pbs_pkg::NUM_SLOT];
    logic [31:0] bar_base [pbs_pkg::NUM_SLOT];
    logic [63:0] bar_mask [pbs_pkg::NUM_SLOT];
    logic [31:0] bar_rd [pbs_pkg::NUM_SLOT];
    logic [pbs_pkg::NUM_SLOT-1:0] bar_ok;
    logic [pbs_pkg::NUM_SLOT-1:0] bar_warn;
    logic [pbs_pkg::NUM_SLOT-1:0] upper;
    logic [pbs_pkg::NUM_SLOT-1:0] ok_q;
    logic [pbs_pkg::NUM_SLOT-1:0] upper_q;
    logic rom_en;
    logic [5:0] rom_size;
    logic [31:0] rom_base;
    logic [63:0] rom_mask;
    logic rom_ok;
    logic rom_warn;
    logic [3:0] sl;
    logic pf;
    logic word_ok;
    logic cfg_sel;
    logic base_sel;
    logic sr_sel;
    logic [31:0] next_rdata;
    pbs_pkg::pbs_hit_s next_hit;

    function automatic logic [31:0] cfg_word(input pbs_pkg::pbs_bar_cfg_s c);
        logic [31:0] w;
        w = '0;
        w[pbs_pkg::CFG_EN_BIT] = c.en;
        w[pbs_pkg::CFG_IO_BIT] = c.io;
        w[pbs_pkg::CFG_64_BIT] = c.is64;
        w[pbs_pkg::CFG_PREF_BIT] = c.pref;
        w[pbs_pkg::CFG_SIZE_LSB +: 6] = c.size;
        return w;
    endfunction

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'h1};
        end
    end
    assign rst_sync_b = rst_pipe[1];

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    assign sl = reg_addr[5:2];
    assign pf = reg_addr[5];
    assign word_ok = (reg_addr[1:0] == 2'h0);
    assign cfg_sel = word_ok && (reg_addr[11:6] == pbs_pkg::ADDR_BAR_CFG[11:6])
        && (32'(sl) < pbs_pkg::NUM_SLOT);
    assign base_sel = word_ok && (reg_addr[11:6] == pbs_pkg::ADDR_BAR_BASE[11:6])
        && (32'(sl) < pbs_pkg::NUM_SLOT);
    assign sr_sel = word_ok && (reg_addr[11:6] == pbs_pkg::ADDR_SRIOV[11:6]);

    // ----------------------------------------
    // Device mode
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ctrl_legacy <= 1'h0;
            ctrl_root <= 1'h0;
        end else if (reg_we && reg_addr == pbs_pkg::ADDR_CTRL) begin
            ctrl_legacy <= reg_wdata[pbs_pkg::CTRL_LEGACY_BIT];
            ctrl_root <= reg_wdata[pbs_pkg::CTRL_ROOT_BIT];
        end
    end

    // ----------------------------------------
    // BAR settings and base addresses
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            for (int i = 0; i < pbs_pkg::NUM_SLOT; i++) begin
                bar_cfg[i] <= '{en: 1'h0, io: 1'h0, is64: 1'h0, pref: 1'h0, size: pbs_pkg::RST_BAR_SIZE};
            end
        end else if (reg_we && cfg_sel) begin
            bar_cfg[sl].en <= reg_wdata[pbs_pkg::CFG_EN_BIT];
            bar_cfg[sl].io <= reg_wdata[pbs_pkg::CFG_IO_BIT];
            bar_cfg[sl].is64 <= reg_wdata[pbs_pkg::CFG_64_BIT];
            bar_cfg[sl].pref <= reg_wdata[pbs_pkg::CFG_PREF_BIT];
            bar_cfg[sl].size <= reg_wdata[pbs_pkg::CFG_SIZE_LSB +: 6];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            for (int i = 0; i < pbs_pkg::NUM_SLOT; i++) begin
                bar_base[i] <= 32'h0000_0000;
            end
        end else if (reg_we && base_sel) begin
            bar_base[sl] <= reg_wdata;
        end
    end

    // ----------------------------------------
    // Legality, masks and readback per slot
    // ----------------------------------------
    always_comb begin
        int s;
        int pv;
        int lim;
        logic [5:0] min_sz;
        logic [5:0] max_sz;
        s = 0;
        pv = 0;
        lim = 0;
        min_sz = '0;
        max_sz = '0;
        for (int i = 0; i < pbs_pkg::NUM_SLOT; i++) begin
            s = i % pbs_pkg::SET_SLOTS;
            pv = (i + pbs_pkg::NUM_SLOT - 1) % pbs_pkg::NUM_SLOT;
            if (!ctrl_root) begin
                lim = pbs_pkg::SET_SLOTS;
            end else if (i < pbs_pkg::SET_SLOTS) begin
                lim = pbs_pkg::ROOT_SLOTS;
            end else begin
                lim = 0;
            end
            bar_mask[i] = ~((64'h1 << bar_cfg[i].size) - 64'h1);
            upper[i] = (s != 0) && bar_cfg[pv].en && !bar_cfg[pv].io && bar_cfg[pv].is64;
            min_sz = ctrl_legacy ? pbs_pkg::SZ_MIN_LEGACY : pbs_pkg::SZ_MIN_NATIVE;
            max_sz = bar_cfg[i].is64 ? pbs_pkg::SZ_MAX_64 : pbs_pkg::SZ_MAX_32;
            bar_ok[i] = bar_cfg[i].en && !upper[i] && (s < lim) && (bar_cfg[i].size <= max_sz);
            if (bar_cfg[i].is64 && (s + 1 >= lim)) begin
                bar_ok[i] = 1'h0;
            end
            if (bar_cfg[i].io) begin
                // I/O space: legacy only, 32-bit, no prefetch
                if (!ctrl_legacy || bar_cfg[i].is64 || bar_cfg[i].pref
                    || bar_cfg[i].size < pbs_pkg::SZ_MIN_IO) begin
                    bar_ok[i] = 1'h0;
                end
            end else begin
                if (bar_cfg[i].size < min_sz) begin
                    bar_ok[i] = 1'h0;
                end
                if (!ctrl_legacy && bar_cfg[i].pref && !bar_cfg[i].is64 && s != pbs_pkg::PREF32_SLOT) begin
                    bar_ok[i] = 1'h0;
                end
            end
            bar_warn[i] = bar_ok[i] && (bar_cfg[i].io || bar_cfg[i].size < pbs_pkg::SZ_MEM_ADVISED);
            if (upper[i]) begin
                bar_rd[i] = bar_base[i] & bar_mask[pv][63:32];
            end else begin
                bar_rd[i] = {bar_base[i][31:4] & bar_mask[i][31:4],
                    bar_cfg[i].pref & ~bar_cfg[i].io, bar_cfg[i].is64 & ~bar_cfg[i].io,
                    1'h0, bar_cfg[i].io};
            end
        end
    end

    // ----------------------------------------
    // Expansion ROM
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rom_en <= 1'h0;
            rom_size <= pbs_pkg::RST_ROM_SIZE;
        end else if (reg_we && reg_addr == pbs_pkg::ADDR_ROM_CFG) begin
            rom_en <= reg_wdata[pbs_pkg::CFG_EN_BIT];
            rom_size <= reg_wdata[pbs_pkg::CFG_SIZE_LSB +: 6];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rom_base <= 32'h0000_0000;
        end else if (reg_we && reg_addr == pbs_pkg::ADDR_ROM_BASE) begin
            rom_base <= reg_wdata & pbs_pkg::ROM_LOW_MASK;
        end
    end

    assign rom_mask = ~((64'h1 << rom_size) - 64'h1);
    assign rom_ok = rom_en && rom_size >= pbs_pkg::SZ_ROM_MIN && rom_size <= pbs_pkg::SZ_ROM_MAX;
    assign rom_warn = rom_ok && rom_size > pbs_pkg::SZ_ROM_ADVISED;

    // ----------------------------------------
    // SR-IOV capability settings
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            for (int p = 0; p < pbs_pkg::NUM_PF; p++) begin
                sriov_cfg[p] <= '{ver: 4'h0, num_vf: 3'h0, vf_devid: 16'h0000,
                    first_off: 16'h0000, dep_link: 16'h0000, page_size: pbs_pkg::RST_PAGE};
            end
        end else if (reg_we && sr_sel) begin
            case (reg_addr[4:2])
                pbs_pkg::SR_VER: begin
                    sriov_cfg[pf].ver <= reg_wdata[3:0];
                end
                pbs_pkg::SR_NUMVF: begin
                    // Counts above the limit saturate
                    if (reg_wdata > 32'(pbs_pkg::MAX_VF)) begin
                        sriov_cfg[pf].num_vf <= 3'(pbs_pkg::MAX_VF);
                    end else begin
                        sriov_cfg[pf].num_vf <= reg_wdata[2:0];
                    end
                end
                pbs_pkg::SR_DEVID: begin
                    sriov_cfg[pf].vf_devid <= reg_wdata[15:0];
                end
                pbs_pkg::SR_FIRST: begin
                    sriov_cfg[pf].first_off <= reg_wdata[15:0];
                end
                pbs_pkg::SR_DEP: begin
                    sriov_cfg[pf].dep_link <= reg_wdata[15:0];
                end
                pbs_pkg::SR_PAGE: begin
                    sriov_cfg[pf].page_size <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Register readback, free of side effects
    // ----------------------------------------
    always_comb begin
        next_rdata = '0;
        if (reg_addr == pbs_pkg::ADDR_CTRL) begin
            next_rdata[pbs_pkg::CTRL_LEGACY_BIT] = ctrl_legacy;
            next_rdata[pbs_pkg::CTRL_ROOT_BIT] = ctrl_root;
        end else if (reg_addr == pbs_pkg::ADDR_OK) begin
            next_rdata = {{(32 - pbs_pkg::NUM_SLOT - 1){1'h0}}, rom_ok, bar_ok};
        end else if (reg_addr == pbs_pkg::ADDR_WARN) begin
            next_rdata = {{(32 - pbs_pkg::NUM_SLOT - 1){1'h0}}, rom_warn, bar_warn};
        end else if (reg_addr == pbs_pkg::ADDR_ROM_CFG) begin
            next_rdata[pbs_pkg::CFG_EN_BIT] = rom_en;
            next_rdata[pbs_pkg::CFG_SIZE_LSB +: 6] = rom_size;
        end else if (reg_addr == pbs_pkg::ADDR_ROM_BASE) begin
            next_rdata = rom_base & rom_mask[31:0] & pbs_pkg::ROM_LOW_MASK;
            next_rdata[pbs_pkg::ROM_EN_BIT] = rom_en;
        end else if (cfg_sel) begin
            next_rdata = cfg_word(bar_cfg[sl]);
        end else if (base_sel) begin
            next_rdata = bar_rd[sl];
        end else if (sr_sel) begin
            case (reg_addr[4:2])
                pbs_pkg::SR_VER: next_rdata = {28'h0, sriov_cfg[pf].ver};
                pbs_pkg::SR_NUMVF: next_rdata = {29'h0, sriov_cfg[pf].num_vf};
                pbs_pkg::SR_DEVID: next_rdata = {16'h0000, sriov_cfg[pf].vf_devid};
                pbs_pkg::SR_FIRST: next_rdata = {16'h0000, sriov_cfg[pf].first_off};
                pbs_pkg::SR_DEP: next_rdata = {16'h0000, sriov_cfg[pf].dep_link};
                pbs_pkg::SR_PAGE: next_rdata = sriov_cfg[pf].page_size;
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= reg_re ? next_rdata : 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // Request decode, lowest slot wins over ROM
    // ----------------------------------------
    always_comb begin
        logic [63:0] base;
        base = '0;
        next_hit = '0;
        if (req_valid && rom_ok && !req_io
            && ((req_addr & rom_mask) == ({32'h0000_0000, rom_base} & rom_mask))) begin
            next_hit.hit = 1'h1;
            next_hit.rom = 1'h1;
        end
        for (int i = pbs_pkg::NUM_SLOT - 1; i >= 0; i--) begin
            base = {(bar_cfg[i].is64 ? bar_base[(i + 1) % pbs_pkg::NUM_SLOT] : 32'h0000_0000), bar_base[i]};
            if (req_valid && bar_ok[i] && (req_io == bar_cfg[i].io)
                && ((req_addr & bar_mask[i]) == (base & bar_mask[i]))) begin
                next_hit.hit = 1'h1;
                next_hit.rom = 1'h0;
                next_hit.io = bar_cfg[i].io;
                next_hit.pref = bar_cfg[i].pref & ~bar_cfg[i].io;
                next_hit.slot = 4'(i);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            hit <= '0;
        end else begin
            hit <= next_hit;
        end
    end

    // Snapshot of legality beside each decode result
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ok_q <= '0;
            upper_q <= '0;
        end else begin
            ok_q <= bar_ok;
            upper_q <= upper;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_hit_ok;
        @(posedge clk_sys) disable iff (!rst_sync_b)
        hit.hit && !hit.rom |-> ok_q[hit.slot];
    endproperty
    a_hit_ok: assert property (p_hit_ok) else $error("hit on disabled slot");

    property p_hit_not_upper;
        @(posedge clk_sys) disable iff (!rst_sync_b)
        hit.hit && !hit.rom |-> !upper_q[hit.slot];
    endproperty
    a_hit_not_upper: assert property (p_hit_not_upper) else $error("hit on upper half");

    property p_space_match;
        @(posedge clk_sys) disable iff (!rst_sync_b)
        hit.hit |-> (hit.io == $past(req_io)) && (!hit.rom || !hit.io);
    endproperty
    a_space_match: assert property (p_space_match) else $error("space type mismatch");

    property p_no_req_no_hit;
        @(posedge clk_sys) disable iff (!rst_sync_b)
        !req_valid |=> !hit.hit;
    endproperty
    a_no_req_no_hit: assert property (p_no_req_no_hit) else $error("hit without request");

    property p_root_slots;
        @(posedge clk_sys) disable iff (!rst_sync_b)
        ctrl_root |-> (bar_ok[pbs_pkg::NUM_SLOT-1:pbs_pkg::ROOT_SLOTS] == '0);
    endproperty
    a_root_slots: assert property (p_root_slots) else $error("root port slot overrun");

    property p_numvf;
        @(posedge clk_sys) disable iff (!rst_sync_b)
        reg_we && sr_sel && reg_addr[4:2] == pbs_pkg::SR_NUMVF
        |=> sriov_cfg[$past(pf)].num_vf <= 3'(pbs_pkg::MAX_VF);
    endproperty
    a_numvf: assert property (p_numvf) else $error("vf count above limit");

    property p_rom_sizing;
        @(posedge clk_sys) disable iff (!rst_sync_b)
        reg_re && reg_addr == pbs_pkg::ADDR_ROM_BASE
        |=> (reg_rdata[31:1] & ~pbs_pkg::ROM_LOW_MASK[31:1]) == '0;
    endproperty
    a_rom_sizing: assert property (p_rom_sizing) else $error("rom low bits not zero");

    property p_ver_write;
        @(posedge clk_sys) disable iff (!rst_sync_b)
        reg_we && sr_sel && reg_addr[4:2] == pbs_pkg::SR_VER
        |=> sriov_cfg[$past(pf)].ver == $past(reg_wdata[3:0]);
    endproperty
    a_ver_write: assert property (p_ver_write) else $error("version not stored");

    for (genvar g = 0; g < pbs_pkg::NUM_SLOT; g++) begin : g_slot_chk
        property p_io_legacy;
            @(posedge clk_sys) disable iff (!rst_sync_b)
            bar_ok[g] && bar_cfg[g].io |-> ctrl_legacy && !bar_cfg[g].is64 && !bar_cfg[g].pref;
        endproperty
        a_io_legacy: assert property (p_io_legacy) else $error("illegal io bar");

        property p_min_size;
            @(posedge clk_sys) disable iff (!rst_sync_b)
            bar_ok[g] && !bar_cfg[g].io
            |-> bar_cfg[g].size >= (ctrl_legacy ? pbs_pkg::SZ_MIN_LEGACY : pbs_pkg::SZ_MIN_NATIVE);
        endproperty
        a_min_size: assert property (p_min_size) else $error("aperture too small");

        property p_pref64;
            @(posedge clk_sys) disable iff (!rst_sync_b)
            bar_ok[g] && !ctrl_legacy && bar_cfg[g].pref && !bar_cfg[g].io
            && (g % pbs_pkg::SET_SLOTS != pbs_pkg::PREF32_SLOT) |-> bar_cfg[g].is64;
        endproperty
        a_pref64: assert property (p_pref64) else $error("prefetchable bar not 64-bit");
    end

    c_sriov_hit: cover property (@(posedge clk_sys) disable iff (!rst_sync_b)
        hit.hit && !hit.rom && hit.slot >= 4'(pbs_pkg::SET_SLOTS));
    c_rom_hit: cover property (@(posedge clk_sys) disable iff (!rst_sync_b) hit.hit && hit.rom);
    c_io_hit: cover property (@(posedge clk_sys) disable iff (!rst_sync_b) hit.hit && hit.io);
    c_upper_read: cover property (@(posedge clk_sys) disable iff (!rst_sync_b)
        reg_re && base_sel && upper[sl]);

endmodule // pbs_bar_sriov_config
`default_nettype wire

/* File: pbs_pkg.sv */
`default_nettype none
package pbs_pkg;
    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int NUM_SLOT = 12;
    localparam int SET_SLOTS = 6;
    localparam int ROOT_SLOTS = 2;
    localparam int NUM_PF = 2;
    localparam int MAX_VF = 6;
    localparam int PREF32_SLOT = 5;
    // ----------------------------------------
    // Aperture limits, log2 of bytes
    // ----------------------------------------
    localparam logic [5:0] SZ_MIN_IO = 6'h04;
    localparam logic [5:0] SZ_MIN_LEGACY = 6'h04;
    localparam logic [5:0] SZ_MIN_NATIVE = 6'h07;
    localparam logic [5:0] SZ_MAX_32 = 6'h1f;
    localparam logic [5:0] SZ_MAX_64 = 6'h3f;
    localparam logic [5:0] SZ_ROM_MIN = 6'h0b;
    localparam logic [5:0] SZ_ROM_MAX = 6'h20;
    localparam logic [5:0] SZ_ROM_ADVISED = 6'h18;
    localparam logic [5:0] SZ_MEM_ADVISED = 6'h0c;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_OK = 12'h004;
    localparam logic [11:0] ADDR_WARN = 12'h008;
    localparam logic [11:0] ADDR_ROM_CFG = 12'h00c;
    localparam logic [11:0] ADDR_ROM_BASE = 12'h010;
    localparam logic [11:0] ADDR_BAR_CFG = 12'h040;
    localparam logic [11:0] ADDR_BAR_BASE = 12'h080;
    localparam logic [11:0] ADDR_SRIOV = 12'h100;
    localparam logic [2:0] SR_VER = 3'h0;
    localparam logic [2:0] SR_NUMVF = 3'h1;
    localparam logic [2:0] SR_DEVID = 3'h2;
    localparam logic [2:0] SR_FIRST = 3'h3;
    localparam logic [2:0] SR_DEP = 3'h4;
    localparam logic [2:0] SR_PAGE = 3'h5;
    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int CTRL_LEGACY_BIT = 0;
    localparam int CTRL_ROOT_BIT = 1;
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_IO_BIT = 1;
    localparam int CFG_64_BIT = 2;
    localparam int CFG_PREF_BIT = 3;
    localparam int CFG_SIZE_LSB = 8;
    localparam int ROM_EN_BIT = 0;
    localparam logic [5:0] RST_BAR_SIZE = 6'h0c;
    localparam logic [5:0] RST_ROM_SIZE = 6'h0b;
    localparam logic [31:0] RST_PAGE = 32'h0000_0001;
    localparam logic [31:0] ROM_LOW_MASK = 32'hffff_f800;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic en;
        logic io;
        logic is64;
        logic pref;
        logic [5:0] size;
    } pbs_bar_cfg_s;
    typedef struct packed {
        logic hit;
        logic rom;
        logic io;
        logic pref;
        logic [3:0] slot;
    } pbs_hit_s;
    typedef struct packed {
        logic [3:0] ver;
        logic [2:0] num_vf;
        logic [15:0] vf_devid;
        logic [15:0] first_off;
        logic [15:0] dep_link;
        logic [31:0] page_size;
    } pbs_sriov_s;
endpackage
`default_nettype wire

/* File: pbs_host.sv */
`timescale 1ns/1ns
`default_nettype none
module pbs_host (
    // Clock
    input wire logic clk_sys,
    // Register port
    output logic [11:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_we,
    output logic reg_re,
    input wire logic [31:0] reg_rdata,
    // Request decode
    output logic req_valid,
    output logic req_io,
    output logic [63:0] req_addr,
    input wire pbs_pkg::pbs_hit_s hit
);
    // ----------------------------------------
    // Host side access tasks
    // ----------------------------------------
    initial begin
        {reg_addr, reg_wdata, reg_we, reg_re, req_valid, req_io, req_addr} = '0;
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_we <= 1'b0;
        reg_wdata <= ~v;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        @(posedge clk_sys);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_re <= 1'b0;
        #1 q = reg_rdata;
    endtask
    task automatic probe(input logic io, input logic [63:0] a, output pbs_pkg::pbs_hit_s q);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_io <= io;
        req_addr <= a;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        req_addr <= ~a;
        #1 q = hit;
    endtask
endmodule // pbs_host
`default_nettype wire

/* File: pbs_bar_sriov_config_test.sv */
`timescale 1ns/1ns
`default_nettype none
module pbs_bar_sriov_config_test;
    // ----------------------------------------
    // Harness
    // ----------------------------------------
    logic clk_sys, rst_b, reg_we, reg_re, req_valid, req_io;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [63:0] req_addr;
    pbs_pkg::pbs_hit_s hit, h;
    pbs_pkg::pbs_sriov_s [pbs_pkg::NUM_PF-1:0] sriov_cfg;
    int err_total = 0;
    int checks_done = 0;
    pbs_bar_sriov_config i_pbs_bar_sriov_config (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .req_valid(req_valid),
        .req_io(req_io), .req_addr(req_addr), .hit(hit), .sriov_cfg(sriov_cfg));
    pbs_host i_pbs_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .req_valid(req_valid), .req_io(req_io), .req_addr(req_addr),
        .hit(hit));
    task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp_hit(input string what, input logic [7:0] e, input pbs_pkg::pbs_hit_s g);
        cmp_word(what, {24'h00_0000, e}, {24'h00_0000, g});
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (2000) @(posedge clk_sys);
        err_total++;
        close_out();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        rst_b = 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        i_pbs_host.rd(pbs_pkg::ADDR_BAR_CFG, d);
        cmp_word("bar0 cfg", 32'h0000_0c00, d);
        cmp_word("page size", 32'h0000_0001, sriov_cfg[0].page_size);
        $display("reset test done");
        i_pbs_host.wr(pbs_pkg::ADDR_BAR_CFG, 32'h0000_0c01);
        i_pbs_host.wr(pbs_pkg::ADDR_BAR_BASE, 32'hffff_ffff);
        i_pbs_host.rd(pbs_pkg::ADDR_BAR_BASE, d);
        cmp_word("bar0 sizing", 32'hffff_f000, d);
        i_pbs_host.wr(pbs_pkg::ADDR_BAR_BASE, 32'h1000_0000);
        i_pbs_host.probe(1'b0, 64'h0000_0000_1000_0010, h);
        cmp_hit("mem hit", 8'h80, h);
        i_pbs_host.probe(1'b1, 64'h0000_0000_1000_0010, h);
        cmp_hit("io miss", 8'h00, h);
        i_pbs_host.wr(pbs_pkg::ADDR_BAR_CFG, 32'h0000_0c00);
        i_pbs_host.probe(1'b0, 64'h0000_0000_1000_0010, h);
        cmp_hit("disabled", 8'h00, h);
        i_pbs_host.wr(pbs_pkg::ADDR_BAR_CFG, 32'h0000_0c01);
        $display("decode test done");
        i_pbs_host.wr(pbs_pkg::ADDR_BAR_CFG + 12'h004, 32'h0000_0601);
        i_pbs_host.rd(pbs_pkg::ADDR_OK, d);
        cmp_word("ok native", 32'h0000_0001, d & 32'h0000_0fff);
        i_pbs_host.wr(pbs_pkg::ADDR_CTRL, 32'h0000_0001);
        i_pbs_host.rd(pbs_pkg::ADDR_OK, d);
        cmp_word("ok legacy", 32'h0000_0003, d & 32'h0000_0fff);
        i_pbs_host.wr(pbs_pkg::ADDR_CTRL, 32'h0000_0000);
        i_pbs_host.wr(pbs_pkg::ADDR_BAR_CFG + 12'h004, 32'h0000_0000);
        i_pbs_host.wr(pbs_pkg::ADDR_BAR_CFG + 12'h008, 32'h0000_0c05);
        i_pbs_host.wr(pbs_pkg::ADDR_BAR_CFG + 12'h010, 32'h0000_0c09);
        i_pbs_host.rd(pbs_pkg::ADDR_OK, d);
        cmp_word("ok pref32", 32'h0000_0005, d & 32'h0000_0fff);
        i_pbs_host.wr(pbs_pkg::ADDR_BAR_BASE + 12'h00c, 32'h0000_0001);
        i_pbs_host.wr(pbs_pkg::ADDR_BAR_BASE + 12'h008, 32'h2000_0000);
        i_pbs_host.rd(pbs_pkg::ADDR_BAR_BASE + 12'h008, d);
        cmp_word("bar2 type", 32'h2000_0004, d);
        i_pbs_host.probe(1'b0, 64'h0000_0001_2000_0040, h);
        cmp_hit("64 hit", 8'h82, h);
        i_pbs_host.probe(1'b0, 64'h0000_0000_2000_0040, h);
        cmp_hit("64 upper miss", 8'h00, h);
        i_pbs_host.wr(pbs_pkg::ADDR_BAR_CFG + 12'h008, 32'h0000_0c0d);
        i_pbs_host.probe(1'b0, 64'h0000_0001_2000_0040, h);
        cmp_hit("pref hit", 8'h92, h);
        i_pbs_host.wr(pbs_pkg::ADDR_BAR_CFG + 12'h018, 32'h0000_0c01);
        i_pbs_host.wr(pbs_pkg::ADDR_BAR_BASE + 12'h018, 32'h4000_0000);
        i_pbs_host.probe(1'b0, 64'h0000_0000_4000_0004, h);
        cmp_hit("sriov bar hit", 8'h86, h);
        i_pbs_host.wr(pbs_pkg::ADDR_CTRL, 32'h0000_0002);
        i_pbs_host.rd(pbs_pkg::ADDR_OK, d);
        cmp_word("ok root", 32'h0000_0001, d);
        i_pbs_host.wr(pbs_pkg::ADDR_CTRL, 32'h0000_0001);
        i_pbs_host.wr(pbs_pkg::ADDR_BAR_CFG + 12'h010, 32'h0000_0403);
        i_pbs_host.probe(1'b1, 64'h0000_0000_0000_0008, h);
        cmp_hit("io hit", 8'ha4, h);
        i_pbs_host.rd(pbs_pkg::ADDR_WARN, d);
        cmp_word("warn io", 32'h0000_0010, d);
        i_pbs_host.wr(pbs_pkg::ADDR_ROM_CFG, 32'h0000_0b01);
        i_pbs_host.wr(pbs_pkg::ADDR_ROM_BASE, 32'h3000_0fff);
        i_pbs_host.rd(pbs_pkg::ADDR_ROM_BASE, d);
        cmp_word("rom base", 32'h3000_0801, d);
        i_pbs_host.probe(1'b0, 64'h0000_0000_3000_0810, h);
        cmp_hit("rom hit", 8'hc0, h);
        $display("aperture test done");
        i_pbs_host.wr(pbs_pkg::ADDR_SRIOV + 12'h004, 32'h0000_0007);
        i_pbs_host.rd(pbs_pkg::ADDR_SRIOV + 12'h004, d);
        cmp_word("num vf", 32'h0000_0006, d);
        cmp_word("num vf out", 32'h0000_0006, {29'h0, sriov_cfg[0].num_vf});
        i_pbs_host.wr(pbs_pkg::ADDR_SRIOV, 32'h0000_0005);
        i_pbs_host.wr(pbs_pkg::ADDR_SRIOV + 12'h00c, 32'h0000_1234);
        i_pbs_host.wr(pbs_pkg::ADDR_SRIOV + 12'h010, 32'h0000_00ff);
        i_pbs_host.wr(pbs_pkg::ADDR_SRIOV + 12'h028, 32'h0000_abcd);
        @(negedge clk_sys);
        cmp_word("version", 32'h0000_0005, {28'h0, sriov_cfg[0].ver});
        cmp_word("first vf", 32'h0000_1234, {16'h0000, sriov_cfg[0].first_off});
        cmp_word("dep link", 32'h0000_00ff, {16'h0000, sriov_cfg[0].dep_link});
        cmp_word("vf devid", 32'h0000_abcd, {16'h0000, sriov_cfg[1].vf_devid});
        $display("sriov test done");
        close_out();
    end
endmodule // pbs_bar_sriov_config_test
`default_nettype wire
